// ==== design/ashp_pkg.sv ====
package ashp_pkg;
   // Host data width and synchronised pin vector
   localparam int          DW       = 8;
   localparam int          PIN_W    = 20;
   localparam logic [19:0] PIN_IDLE = 20'h0003e;
   // Register offsets on the three select bits
   localparam logic [2:0] OFS_DATA  = 3'h0;
   localparam logic [2:0] OFS_IEN   = 3'h1;
   localparam logic [2:0] OFS_IID   = 3'h2;
   localparam logic [2:0] OFS_LCTL  = 3'h3;
   localparam logic [2:0] OFS_MCTL  = 3'h4;
   localparam logic [2:0] OFS_LSTAT = 3'h5;
   localparam logic [2:0] OFS_MSTAT = 3'h6;
   localparam logic [2:0] OFS_SCR   = 3'h7;
   // Field positions
   localparam int LC_STOP = 2;
   localparam int LC_PEN  = 3;
   localparam int LC_EVEN = 4;
   localparam int LC_BRK  = 6;
   localparam int LC_DLAB = 7;
   localparam int MC_RTS  = 1;
   localparam int MC_LOOP = 4;
   localparam int FC_EN   = 0;
   localparam int FC_RXCL = 1;
   localparam int FC_TXCL = 2;
   localparam int LS_OE   = 1;
   localparam int LS_PE   = 2;
   localparam int LS_BI   = 4;
   localparam int MS_CLEAR_TO_SEND_DELTA = 0;
   localparam int MS_CTS  = 4;
   localparam int IE_RX   = 0;
   localparam int IE_TX   = 1;
   localparam int IE_LS   = 2;
   localparam int IE_MS   = 3;
   // Interrupt identity codes, highest priority first
   localparam logic [3:0] IID_LS   = 4'h6;
   localparam logic [3:0] IID_RX   = 4'h4;
   localparam logic [3:0] IID_TX   = 4'h2;
   localparam logic [3:0] IID_MS   = 4'h0;
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [7:0] IID_FON  = 8'hc0;
   // Reset values and divider limits
   localparam logic [7:0]  REG_RST = 8'h00;
   localparam logic [15:0] DIV_MIN = 16'h0001;
   // Character framing in sixteenth-of-bit ticks
   localparam logic [5:0] HALF_END = 6'h07;
   localparam logic [5:0] BIT_END  = 6'h0f;
   localparam logic [5:0] S15_END  = 6'h17;
   localparam logic [5:0] S2_END   = 6'h1f;
   localparam logic [2:0] LEN_BASE = 3'h4;
   localparam logic [1:0] WL_MAX   = 2'h3;
   localparam logic [7:0] FULL_MSK = 8'hff;
   localparam int         RX_ERR_W = 3;
   // Serial framer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_DATA  = 3'b010,
      ST_PAR   = 3'b011,
      ST_STOP  = 3'b100
   } ashp_ser_e;
endpackage : ashp_pkg

// ==== design/ashp_fifo_if.sv ====
// Push/pull pair between the block and one of its queues
interface ashp_fifo_if #(
   parameter int W = 8
);
   logic         push;
   logic         pull;
   logic         clear;
   logic         one_deep;
   logic         ready;
   logic         valid;
   logic [W-1:0] wdata;
   logic [W-1:0] rdata;
   modport store (input push, pull, clear, one_deep, wdata,
                  output ready, valid, rdata);
   modport user  (output push, pull, clear, one_deep, wdata,
                  input ready, valid, rdata);
endinterface : ashp_fifo_if

// ==== design/ashp_fifo.sv ====
module ashp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input logic        clk,
   input logic        rst_n,
   // Queue port
   ashp_fifo_if.store f
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW-1:0] rp_nxt;
   logic [AW:0]   cnt_r;
   logic [W-1:0]  rd_r;
   logic          do_push;
   logic          do_pull;

   // Single-deep limit gives the holding-register behaviour
   assign f.ready = f.one_deep ? (cnt_r == '0)
                               : (cnt_r != (AW+1)'(DEPTH));
   assign f.valid = (cnt_r != '0);
   assign f.rdata = rd_r;
   assign do_push = f.push & f.ready;
   assign do_pull = f.pull & f.valid;
   assign rp_nxt  = rp_r + AW'(do_pull);

   // Storage needs no reset; DEPTH must be a power of two
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wp_r] <= f.wdata;
      end
   end

   // Head register, bypassed when the head slot is written now
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_r <= '0;
      end else if (do_push && wp_r == rp_nxt) begin
         rd_r <= f.wdata;
      end else begin
         rd_r <= mem[rp_nxt];
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else if (f.clear) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_r + AW'(do_push);
         rp_r  <= rp_nxt;
         cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pull);
      end
   end
endmodule : ashp_fifo

// ==== design/ashp_top.sv ====
// What this block does
// - Strobe low passes selects straight through
// - Strobe rise freezes selects while high
// - Selected only first, second high, third low
// - Rate clock is reference over divisor for divisors two and up
// - Any divisor one to 65535 accepted
// - Modem status bit 4 shows clear-to-send
// - Bit 0 flags clear-to-send change, read clears
// - Enabled clear-to-send change raises interrupt
// - Data bus driven only during reads
// - Three select bits pick the register
// - FIFO mode queues sixteen entries with errors
// - Reset starts in single-buffer character mode
// - Software can leave FIFO mode again
// - Character length five to eight bits
// - Even, odd or no parity both ways
// - One, one and half, or two stops
// - Frame on transmit, strip on receive
// - Short low pulse is no start bit
// - Break sent on command and detected
// - Loopback with simulated line errors
// - Four interrupt sources, enables, fixed priority
module ashp_top #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input  logic                  SYS_CLK,
   input  logic                  RST_N,
   // Host select pins
   input  logic                  REG_SELECT_BIT_LOW,
   input  logic                  REG_SELECT_BIT_MID,
   input  logic                  REG_SELECT_BIT_HIGH,
   input  logic                  SELECT_LATCH_STROBE,
   input  logic                  CHIP_SELECT_FIRST_HIGH,
   input  logic                  CHIP_SELECT_SECOND_HIGH,
   input  logic                  CHIP_SELECT_THIRD_LOW,
   input  logic                  READ_STROBE_N,
   input  logic                  WRITE_STROBE_N,
   // Host data bus
   input  logic [ashp_pkg::DW-1:0] HOST_DATA_BUS_IN,
   output logic [ashp_pkg::DW-1:0] HOST_DATA_BUS_OUT,
   output logic                  HOST_DATA_BUS_OE,
   // Serial line and rate clocks
   input  logic                  SERIAL_IN,
   output logic                  SERIAL_OUT,
   input  logic                  RX_RATE_CLOCK_IN,
   output logic                  TX_RATE_CLOCK_OUT,
   // Modem status and interrupt
   input  logic                  CLEAR_TO_SEND_N,
   output logic                  INTERRUPT_REQ
);
   import ashp_pkg::*;
   localparam int RXW = DW + RX_ERR_W;

   logic [PIN_W-1:0] pin_s1_r, pin_s2_r;
   logic [DW-1:0]    d_s;
   logic [2:0]       rs_s, cs_s, adr;
   logic [5:0]       lat_r, sel;
   logic             stb_s, rd_n_s, wr_n_s, sin_s, cts_n_s;
   logic             rclk_s, rclk_d_r, rd_n_d_r, wr_n_d_r;
   logic             chip_on, rd_go, wr_go, dlab;
   logic [7:0]       dll_r, dlm_r, lcr_r, mcr_r, scr_r;
   logic [3:0]       ier_r, iid;
   logic             fifo_en_r, loop, fcr_wr, mode_chg;
   logic [15:0]      div, bd_cnt_r;
   logic             tick_r, bclk_r, rx_tick;
   logic [1:0]       wl;
   logic [2:0]       nlast;
   ashp_ser_e        tx_st_r, rx_st_r;
   logic [7:0]       tx_sh_r, rx_sh_r, rx_data, out_r, rd_mux;
   logic [5:0]       tx_tk_r, rx_tk_r, stop_end;
   logic [2:0]       tx_n_r, rx_n_r, err_r, head_err, errs;
   logic             tx_par_r, rx_par_r, line_bit, sout_r, rx_in;
   logic             rx_push, rx_pe, rx_fe, rx_bi, ovr_r;
   logic             cts_now, cts_d_r, clear_to_send_delta_r, tx_mt_d_r;
   logic             thre_ip_r, intr_r, oe_r;
   logic             rd_lsr, rd_msr, rd_iid, wr_thr;

   ashp_fifo_if #(.W(DW))  txq ();
   ashp_fifo_if #(.W(RXW)) rxq ();

   // Parity over the active character bits only
   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [1:0] w,
                                    input logic       ev);
      par_bit = ^(d & (FULL_MSK >> (WL_MAX - w))) ^ ~ev;
   endfunction : par_bit

   // Every pin passes two flops; RX clock must stay below SYS_CLK/4
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_r <= PIN_IDLE;
         pin_s2_r <= PIN_IDLE;
      end else begin
         pin_s1_r <= {HOST_DATA_BUS_IN, REG_SELECT_BIT_HIGH,
                      REG_SELECT_BIT_MID, REG_SELECT_BIT_LOW,
                      CHIP_SELECT_FIRST_HIGH, CHIP_SELECT_SECOND_HIGH,
                      CHIP_SELECT_THIRD_LOW, SELECT_LATCH_STROBE,
                      READ_STROBE_N, WRITE_STROBE_N, SERIAL_IN,
                      CLEAR_TO_SEND_N, RX_RATE_CLOCK_IN};
         pin_s2_r <= pin_s1_r;
      end
   end
   assign {d_s, rs_s, cs_s, stb_s, rd_n_s, wr_n_s, sin_s, cts_n_s,
           rclk_s} = pin_s2_r;

   // Latch follows while strobe is low, so its rise freezes it
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lat_r <= '0;
      end else if (!stb_s) begin
         lat_r <= {rs_s, cs_s};
      end
   end
   assign sel     = stb_s ? lat_r : {rs_s, cs_s};
   assign adr     = sel[5:3];
   assign chip_on = sel[2] & sel[1] & ~sel[0];

   // Strobe edges; writes take effect at the end of the strobe
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_n_d_r <= 1'b1;
         wr_n_d_r <= 1'b1;
         rclk_d_r <= 1'b0;
      end else begin
         rd_n_d_r <= rd_n_s;
         wr_n_d_r <= wr_n_s;
         rclk_d_r <= rclk_s;
      end
   end
   assign rd_go  = rd_n_d_r & ~rd_n_s & chip_on;
   assign wr_go  = ~wr_n_d_r & wr_n_s & chip_on;
   assign dlab   = lcr_r[LC_DLAB];
   assign loop   = mcr_r[MC_LOOP];
   assign wl     = lcr_r[1:0];
   assign nlast  = 3'(wl) + LEN_BASE;
   assign rd_lsr = rd_go & (adr == OFS_LSTAT);
   assign rd_msr = rd_go & (adr == OFS_MSTAT);
   assign rd_iid = rd_go & (adr == OFS_IID);
   assign wr_thr = wr_go & (adr == OFS_DATA) & ~dlab;
   assign fcr_wr = wr_go & (adr == OFS_IID);
   assign mode_chg = fcr_wr & (d_s[FC_EN] != fifo_en_r);

   // Host-written configuration; reset gives character mode
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dll_r     <= REG_RST;
         dlm_r     <= REG_RST;
         lcr_r     <= REG_RST;
         mcr_r     <= REG_RST;
         scr_r     <= REG_RST;
         ier_r     <= '0;
         fifo_en_r <= 1'b0;
      end else if (wr_go) begin
         case (adr)
            OFS_DATA: if (dlab) dll_r <= d_s;
            OFS_IEN:  if (dlab) dlm_r <= d_s;
                      else ier_r <= d_s[3:0];
            OFS_IID:  fifo_en_r <= d_s[FC_EN];
            OFS_LCTL: lcr_r <= d_s;
            OFS_MCTL: mcr_r <= d_s;
            OFS_SCR:  scr_r <= d_s;
            default:  ;
         endcase
      end
   end

   // Queues: one deep in character mode, flushed on mode change
   assign txq.one_deep = ~fifo_en_r;
   assign rxq.one_deep = ~fifo_en_r;
   assign txq.clear = mode_chg | (fcr_wr & d_s[FC_TXCL]);
   assign rxq.clear = mode_chg | (fcr_wr & d_s[FC_RXCL]);
   assign txq.push  = wr_thr;
   assign txq.wdata = d_s;
   assign txq.pull  = (tx_st_r == ST_IDLE);
   assign rxq.push  = rx_push;
   assign rxq.wdata = {rx_bi, rx_fe, rx_pe, rx_data};
   assign rxq.pull  = rd_go & (adr == OFS_DATA) & ~dlab;

   ashp_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_txq (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .f     (txq)
   );
   ashp_fifo #(.W(RXW), .DEPTH(FIFO_DEPTH)) u_rxq (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .f     (rxq)
   );

   // Rate divider; divisor zero stops it, divisor one runs flat out
   assign div = {dlm_r, dll_r};
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         bd_cnt_r <= DIV_MIN;
         tick_r   <= 1'b0;
         bclk_r   <= 1'b0;
      end else if (div == '0) begin
         tick_r   <= 1'b0;
      end else begin
         tick_r   <= (bd_cnt_r <= DIV_MIN);
         bd_cnt_r <= (bd_cnt_r <= DIV_MIN) ? div : bd_cnt_r - DIV_MIN;
         bclk_r   <= (bd_cnt_r > (div >> 1));
      end
   end
   // Receiver runs from its pin unless looped back
   assign rx_tick = loop ? tick_r : (rclk_s & ~rclk_d_r);

   // Transmit framer: start, data LSB first, parity, stops
   assign stop_end = !lcr_r[LC_STOP] ? BIT_END
                   : (wl == '0) ? S15_END : S2_END;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_st_r  <= ST_IDLE;
         tx_sh_r  <= '0;
         tx_tk_r  <= '0;
         tx_n_r   <= '0;
         tx_par_r <= 1'b0;
      end else if (tx_st_r == ST_IDLE) begin
         if (txq.valid) begin
            tx_sh_r  <= txq.rdata;
            tx_par_r <= par_bit(txq.rdata, wl, lcr_r[LC_EVEN]);
            tx_st_r  <= ST_START;
            tx_tk_r  <= '0;
            tx_n_r   <= '0;
         end
      end else if (tick_r) begin
         tx_tk_r <= tx_tk_r + 1'b1;
         unique case (tx_st_r)
            ST_IDLE:  ;
            ST_START: if (tx_tk_r == BIT_END) begin
               tx_st_r <= ST_DATA;
               tx_tk_r <= '0;
            end
            ST_DATA: if (tx_tk_r == BIT_END) begin
               tx_sh_r <= tx_sh_r >> 1;
               tx_n_r  <= tx_n_r + 1'b1;
               tx_tk_r <= '0;
               if (tx_n_r == nlast) begin
                  tx_st_r <= lcr_r[LC_PEN] ? ST_PAR : ST_STOP;
               end
            end
            ST_PAR: if (tx_tk_r == BIT_END) begin
               tx_st_r <= ST_STOP;
               tx_tk_r <= '0;
            end
            ST_STOP: if (tx_tk_r == stop_end) begin
               tx_st_r <= ST_IDLE;
            end
            default: tx_st_r <= ST_IDLE;
         endcase
      end
   end
   assign line_bit = (tx_st_r == ST_START) ? 1'b0
                   : (tx_st_r == ST_DATA)  ? tx_sh_r[0]
                   : (tx_st_r == ST_PAR)   ? tx_par_r : 1'b1;

   // Loopback holds the pin at mark and feeds the frame inward
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sout_r <= 1'b1;
      end else begin
         sout_r <= loop | (line_bit & ~lcr_r[LC_BRK]);
      end
   end
   assign rx_in = loop ? (line_bit & ~lcr_r[LC_BRK]) : sin_s;

   // Receive framer: confirm start at half bit, then sample mid-bit
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_st_r  <= ST_IDLE;
         rx_tk_r  <= '0;
         rx_n_r   <= '0;
         rx_sh_r  <= '0;
         rx_par_r <= 1'b0;
      end else if (rx_tick) begin
         rx_tk_r <= rx_tk_r + 1'b1;
         unique case (rx_st_r)
            ST_IDLE: if (!rx_in) begin
               rx_st_r <= ST_START;
               rx_tk_r <= '0;
            end
            ST_START: if (rx_tk_r == HALF_END) begin
               rx_st_r <= rx_in ? ST_IDLE : ST_DATA;
               rx_tk_r <= '0;
               rx_n_r  <= '0;
            end
            ST_DATA: if (rx_tk_r == BIT_END) begin
               rx_sh_r <= {rx_in, rx_sh_r[7:1]};
               rx_n_r  <= rx_n_r + 1'b1;
               rx_tk_r <= '0;
               if (rx_n_r == nlast) begin
                  rx_st_r <= lcr_r[LC_PEN] ? ST_PAR : ST_STOP;
               end
            end
            ST_PAR: if (rx_tk_r == BIT_END) begin
               rx_par_r <= rx_in;
               rx_st_r  <= ST_STOP;
               rx_tk_r  <= '0;
            end
            ST_STOP: if (rx_tk_r == BIT_END) begin
               rx_st_r <= ST_IDLE;
            end
            default: rx_st_r <= ST_IDLE;
         endcase
      end
   end
   // Stop sample completes the character; framing bits are dropped
   assign rx_push = rx_tick & (rx_st_r == ST_STOP)
                  & (rx_tk_r == BIT_END);
   assign rx_data = rx_sh_r >> (WL_MAX - wl);
   assign rx_pe = lcr_r[LC_PEN]
                & (par_bit(rx_data, wl, lcr_r[LC_EVEN]) != rx_par_r);
   assign rx_fe = ~rx_in;
   assign rx_bi = ~rx_in & (rx_data == '0)
                & ~(lcr_r[LC_PEN] & rx_par_r);

   // Sticky line errors; the set term wins over the read clear
   assign head_err = rxq.valid ? rxq.rdata[RXW-1:DW] : '0;
   assign errs     = err_r | head_err;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         err_r <= '0;
         ovr_r <= 1'b0;
      end else begin
         err_r <= (rd_lsr ? '0 : err_r)
                | (rxq.pull ? head_err : '0)
                | ((wr_go & loop & (adr == OFS_LSTAT))
                   ? d_s[LS_BI:LS_PE] : '0);
         ovr_r <= (ovr_r & ~rd_lsr) | (rx_push & ~rxq.ready)
                | (wr_go & loop & (adr == OFS_LSTAT) & d_s[LS_OE]);
      end
   end

   // Modem status: change flag set wins over the read clear
   assign cts_now = loop ? mcr_r[MC_RTS] : ~cts_n_s;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cts_d_r   <= 1'b0;
         clear_to_send_delta_r    <= 1'b0;
         tx_mt_d_r <= 1'b1;
         thre_ip_r <= 1'b0;
      end else begin
         cts_d_r   <= cts_now;
         clear_to_send_delta_r    <= (cts_now != cts_d_r) | (clear_to_send_delta_r & ~rd_msr);
         tx_mt_d_r <= ~txq.valid;
         thre_ip_r <= (~txq.valid & tx_mt_d_r ? thre_ip_r : ~txq.valid)
                    & ~(wr_thr | (rd_iid & (iid == IID_TX)))
                    | (~txq.valid & ~tx_mt_d_r);
      end
   end

   // Fixed priority: line status, data, holding empty, modem
   always_comb begin
      iid = IID_NONE;
      if (ier_r[IE_LS] & ((|errs) | ovr_r)) iid = IID_LS;
      else if (ier_r[IE_RX] & rxq.valid)    iid = IID_RX;
      else if (ier_r[IE_TX] & thre_ip_r)    iid = IID_TX;
      else if (ier_r[IE_MS] & clear_to_send_delta_r)       iid = IID_MS;
   end

   // Read data selection
   always_comb begin
      rd_mux = '0;
      case (adr)
         OFS_DATA:  rd_mux = dlab ? dll_r : rxq.rdata[DW-1:0];
         OFS_IEN:   rd_mux = dlab ? dlm_r : 8'(ier_r);
         OFS_IID:   rd_mux = 8'(iid) | (fifo_en_r ? IID_FON : '0);
         OFS_LCTL:  rd_mux = lcr_r;
         OFS_MCTL:  rd_mux = mcr_r;
         OFS_LSTAT: rd_mux = {fifo_en_r & ((|errs) | ovr_r),
                              ~txq.valid & (tx_st_r == ST_IDLE),
                              ~txq.valid, errs, ovr_r, rxq.valid};
         OFS_MSTAT: begin
            rd_mux[MS_CTS]  = cts_now;
            rd_mux[MS_CLEAR_TO_SEND_DELTA] = clear_to_send_delta_r;
         end
         default:   rd_mux = scr_r;
      endcase
   end

   // Bus drive only while a selected read strobe is low
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         out_r  <= '0;
         oe_r   <= 1'b0;
         intr_r <= 1'b0;
      end else begin
         if (rd_go) out_r <= rd_mux;
         oe_r   <= ~rd_n_s & chip_on;
         intr_r <= (iid != IID_NONE);
      end
   end
   assign HOST_DATA_BUS_OUT = out_r;
   assign HOST_DATA_BUS_OE  = oe_r;
   assign SERIAL_OUT        = sout_r;
   assign TX_RATE_CLOCK_OUT = bclk_r;
   assign INTERRUPT_REQ     = intr_r;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_tx_go;
      tx_st_r == ST_IDLE && txq.valid && !loop;
   endsequence
   sequence s_false_start;
      rx_st_r == ST_START && rx_tick && rx_tk_r == HALF_END && rx_in;
   endsequence
   property p_pass;
      !stb_s ##1 stb_s |-> sel == $past({rs_s, cs_s});
   endproperty
   a_pass: assert property (p_pass) else $error("no pass");
   property p_hold;
      stb_s && $past(stb_s) |-> $stable(sel);
   endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_desel;
      !chip_on |=> !HOST_DATA_BUS_OE;
   endproperty
   a_desel: assert property (p_desel) else $error("drove");
   property p_tick;
      tick_r && div > DIV_MIN |=> !tick_r;
   endproperty
   a_tick: assert property (p_tick) else $error("tick");
   property p_cts;
      rd_msr |=> HOST_DATA_BUS_OUT[MS_CTS] == $past(cts_now);
   endproperty
   a_cts: assert property (p_cts) else $error("cts bit");
   property p_clear_to_send_delta;
      cts_now != cts_d_r |=> clear_to_send_delta_r;
   endproperty
   a_clear_to_send_delta: assert property (p_clear_to_send_delta) else $error("clear_to_send_delta");
   property p_msint;
      clear_to_send_delta_r && ier_r[IE_MS] |=> INTERRUPT_REQ;
   endproperty
   a_msint: assert property (p_msint) else $error("no irq");
   property p_brk;
      lcr_r[LC_BRK] && !loop |=> !SERIAL_OUT;
   endproperty
   a_brk: assert property (p_brk) else $error("no break");
   property p_frame;
      s_tx_go |=> ##1 !SERIAL_OUT;
   endproperty
   a_frame: assert property (p_frame) else $error("no start");
   property p_glitch;
      s_false_start |=> rx_st_r == ST_IDLE;
   endproperty
   a_glitch: assert property (p_glitch) else $error("glitch");
endmodule : ashp_top

// ==== sim/ashp_host_model.sv ====
// Host CPU side: register cycles on the strobes, data driven only in writes
module ashp_host_model (
   // Clock and bus wire
   input  logic       clk,
   input  logic [7:0] bus,
   input  logic       oe,
   // Host strobes, selects and write data
   output logic [2:0] rs,
   output logic       rd_n,
   output logic       wr_n,
   output logic       drv,
   output logic [7:0] dat
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {rs, rd_n, wr_n, drv, dat} = {3'h0, 3'h6, 8'h00};
   // Write: strobe low 4 clocks, data held 5 past the rise, since the
   // pins cross two flops before the write edge is seen
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      {rs, dat, drv, wr_n} <= {a, d, 2'b10};
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      repeat (5) @(posedge clk);
      drv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : wr
   // Read: sample the wire 6 clocks into the strobe, well past the lag
   task automatic rd(input logic [2:0] a, output logic [7:0] q,
                     output logic o);
      @(posedge clk);
      {rs, rd_n} <= {a, 1'b0};
      repeat (6) @(posedge clk);
      q = bus;
      o = oe;
      rd_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : rd
endmodule : ashp_host_model

// ==== sim/async_serial_host_port_tb_top.sv ====
module async_serial_host_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ashp_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, select_latch_strobe = 1'b0, cts_n = 1'b1;
   logic       rclk = 1'b0, sin = 1'b1, oe, sout, txc, irq, rd_n, wr_n;
   logic       drv, o;
   logic [2:0] cs = 3'h3, rs;
   logic [7:0] out, dat, bus, q, last = 8'h00;
   int         n_fail = 0, checked = 0, k;
   always #2.5 clk = ~clk;
   // Released wire shows a changing pattern, never the last value
   assign bus = oe ? out : (drv ? dat : ~last);
   // Rate clock looped to the receive clock, serial line looped back
   always @(posedge clk) begin
      last <= bus;
      rclk <= txc;
      sin  <= sout;
   end
   ashp_host_model u_host (.clk(clk), .bus(bus), .oe(oe), .rs(rs),
      .rd_n(rd_n), .wr_n(wr_n), .drv(drv), .dat(dat));
   ashp_top #(.FIFO_DEPTH(16)) dut (.SYS_CLK(clk), .RST_N(rst_n),
      .REG_SELECT_BIT_LOW(rs[0]), .REG_SELECT_BIT_MID(rs[1]),
      .REG_SELECT_BIT_HIGH(rs[2]), .SELECT_LATCH_STROBE(select_latch_strobe),
      .CHIP_SELECT_FIRST_HIGH(cs[0]), .CHIP_SELECT_SECOND_HIGH(cs[1]),
      .CHIP_SELECT_THIRD_LOW(cs[2]), .READ_STROBE_N(rd_n),
      .WRITE_STROBE_N(wr_n), .HOST_DATA_BUS_IN(bus),
      .HOST_DATA_BUS_OUT(out), .HOST_DATA_BUS_OE(oe), .SERIAL_IN(sin),
      .SERIAL_OUT(sout), .RX_RATE_CLOCK_IN(rclk),
      .TX_RATE_CLOCK_OUT(txc), .CLEAR_TO_SEND_N(cts_n),
      .INTERRUPT_REQ(irq));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic summarize;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic rc(input logic [2:0] a, input logic [7:0] e);
      u_host.rd(a, q, o);
      chk(q, e);
      chk({7'h0, o}, 8'h01);
   endtask : rc
   // Poll line status until the masked bits are all set, bounded
   task automatic poll(input logic [7:0] m);
      for (k = 0; k < 400 && (q & m) !== m; k++) u_host.rd(OFS_LSTAT, q, o);
      if ((q & m) !== m) begin
         chk(q & m, m);
         summarize();
      end
   endtask : poll
   task automatic t_reset;
      chk({5'h0, sout, irq, oe}, 8'h04);
      rc(OFS_SCR, REG_RST);
      rc(OFS_IID, 8'h01);
      $display("test reset done");
   endtask : t_reset
   task automatic t_select;
      u_host.wr(OFS_SCR, 8'ha5);
      rc(OFS_SCR, 8'ha5);
      // Each select taken inactive alone: no write, no drive
      for (int i = 0; i < 3; i++) begin
         cs <= 3'h3 ^ (3'h1 << i);
         u_host.wr(OFS_SCR, 8'h3c);
         u_host.rd(OFS_SCR, q, o);
         chk({7'h0, o}, 8'h00);
      end
      cs <= 3'h3;
      rc(OFS_SCR, 8'ha5);
      // Strobe high freezes the selects seen at its rise
      select_latch_strobe <= 1'b1;
      repeat (4) @(posedge clk);
      cs <= 3'h0;
      rc(OFS_SCR, 8'ha5);
      select_latch_strobe <= 1'b0;
      u_host.rd(OFS_SCR, q, o);
      chk({7'h0, o}, 8'h00);
      cs <= 3'h3;
      $display("test select done");
   endtask : t_select
   task automatic t_cts;
      u_host.wr(OFS_IEN, 8'h08);
      cts_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk({7'h0, irq}, 8'h01);
      rc(OFS_MSTAT, 8'h11);
      rc(OFS_MSTAT, 8'h10);
      chk({7'h0, irq}, 8'h00);
      u_host.wr(OFS_IEN, 8'h00);
      $display("test cts done");
   endtask : t_cts
   task automatic t_serial;
      logic [7:0] exp [3] = '{8'h5a, 8'ha5, 8'h00};
      u_host.wr(OFS_LCTL, 8'h80);
      u_host.wr(OFS_DATA, 8'h08);
      u_host.wr(OFS_IEN, 8'h00);
      u_host.wr(OFS_LCTL, 8'h1b);
      // Divisor 8 gives ten rate clock rises in 80 clocks
      k = 0;
      repeat (80) @(posedge clk) k += (txc && !rclk);
      chk(8'(k), 8'h0a);
      u_host.wr(OFS_IID, 8'h01);
      rc(OFS_IID, 8'hc1);
      foreach (exp[i]) u_host.wr(OFS_DATA, exp[i]);
      q = 8'h00;
      poll(8'h41);
      foreach (exp[i]) rc(OFS_DATA, exp[i]);
      rc(OFS_LSTAT, 8'h60);
      u_host.wr(OFS_IID, 8'h00);
      rc(OFS_IID, 8'h01);
      // Break held on the line, seen again by the looped receiver
      u_host.wr(OFS_LCTL, 8'h5b);
      chk({7'h0, sout}, 8'h00);
      q = 8'h00;
      poll(8'h10);
      u_host.wr(OFS_LCTL, 8'h1b);
      $display("test serial done");
   endtask : t_serial
   // Internal loop: pin held at mark, 5-bit odd frame, forced errors
   task automatic t_loop;
      u_host.wr(OFS_MCTL, 8'h10);
      u_host.wr(OFS_LCTL, 8'h0c);
      rc(OFS_MSTAT, 8'h01);
      // Let a frame cut by the break finish, then empty the queue
      repeat (1600) @(posedge clk);
      u_host.wr(OFS_IID, 8'h02);
      u_host.rd(OFS_LSTAT, q, o);
      u_host.wr(OFS_DATA, 8'h15);
      chk({7'h0, sout}, 8'h01);
      q = 8'h00;
      poll(8'h41);
      rc(OFS_DATA, 8'h15);
      u_host.wr(OFS_LSTAT, 8'h12);
      rc(OFS_LSTAT, 8'h72);
      rc(OFS_LSTAT, 8'h60);
      u_host.wr(OFS_MCTL, 8'h00);
      $display("test loop done");
   endtask : t_loop
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset();
      t_select();
      t_cts();
      t_serial();
      t_loop();
      summarize();
   end
endmodule : async_serial_host_port_tb_top
